// *** bench/efc_user_model.sv ***
// far-side user logic: write and read clock enables at unrelated rates
`timescale 1ns/10ps
`default_nettype none
module efc_user_model (
  input wire logic clk,
  input wire logic srst,
  output logic wr_tick,
  output logic rd_tick
);
  logic [1:0] wcnt;
  logic [1:0] rcnt;
  always_ff @(posedge clk) begin
    wcnt <= (srst || wcnt == 2'h1) ? 2'h0 : wcnt + 2'h1;
    rcnt <= (srst || rcnt == 2'h2) ? 2'h0 : rcnt + 2'h1;
  end
  // write side every 2nd cycle, read side every 3rd
  assign wr_tick = (wcnt == 2'h1);
  assign rd_tick = (rcnt == 2'h2);
endmodule
`default_nettype wire

// *** bench/embedded_fifo_controller_test.sv ***
// self-checking bench for the embedded fifo controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module embedded_fifo_controller_test;
  import efc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fifo_clear = 1'b0;
  logic [2:0] width_sel = WIDTH_36;
  logic [3:0] depth_sel = DEPTH_1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] write_data_bus = 36'h000000000;
  logic [THR_W-1:0] almost_full_threshold = 8'h08;
  logic [THR_W-1:0] almost_empty_threshold = 8'h08;
  logic [DATA_W-1:0] read_data_bus;
  logic full_flag, almost_full_flag, empty_flag, almost_empty_flag, wr_tick, rd_tick;
  int miscompares = 0;
  int cmp_count = 0;
  int wbits [6] = '{1, 2, 4, 9, 18, 36};

  efc_fifo u_efc_fifo (.clk(clk), .srst(srst), .fifo_clear(fifo_clear), .width_sel(width_sel),
    .depth_sel(depth_sel), .wr_tick(wr_tick), .wr_en(wr_en), .write_data_bus(write_data_bus),
    .almost_full_threshold(almost_full_threshold), .full_flag(full_flag),
    .almost_full_flag(almost_full_flag), .rd_tick(rd_tick), .rd_en(rd_en),
    .almost_empty_threshold(almost_empty_threshold), .read_data_bus(read_data_bus),
    .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag));
  efc_user_model u_efc_user_model (.clk(clk), .srst(srst), .wr_tick(wr_tick), .rd_tick(rd_tick));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // n write attempts, one per write-side tick, enable held only for them
  task automatic push(input logic [DATA_W-1:0] base, input int n);
    int i = 0;
    @(posedge clk);
    wr_en <= 1'b1;
    write_data_bus <= base;
    while (i < n) begin
      @(posedge clk);
      if (wr_tick === 1'b1) begin
        i++;
        if (i == n) wr_en <= 1'b0;
        else write_data_bus <= base + 36'(i);
      end
    end
    #1;
  endtask

  // n accepted reads, each word checked in the cycle after its edge
  task automatic pop(input logic [DATA_W-1:0] base, input logic [DATA_W-1:0] mask, input int n);
    int i = 0;
    @(posedge clk);
    rd_en <= 1'b1;
    while (i < n) begin
      @(posedge clk);
      if (rd_tick === 1'b1 && empty_flag === 1'b0) begin
        i++;
        if (i == n) rd_en <= 1'b0;
        #1 `CHK(read_data_bus, (base + 36'(i - 1)) & mask)
      end
    end
  endtask

  task automatic clr;
    @(posedge clk);
    fifo_clear <= 1'b1;
    @(posedge clk);
    fifo_clear <= 1'b0;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // fill past full, watch the almost flags, drain, then read while empty
  task automatic fill(input logic [3:0] ds, input int d);
    @(posedge clk);
    depth_sel <= ds;
    clr;
    push(36'h100000000, 63);
    `CHK(almost_full_flag, 1'b0)
    push(36'h10000003F, 1);
    `CHK(almost_full_flag, 1'b1)
    idle(15);
    `CHK(almost_empty_flag, 1'b1)
    push(36'h100000040, d - 62);
    `CHK(full_flag, 1'b1)
    idle(15);
    `CHK(almost_empty_flag, 1'b0)
    `CHK(empty_flag, 1'b0)
    pop(36'h100000000, 36'hFFFFFFFFF, d);
    `CHK(empty_flag, 1'b1)
    @(posedge clk);
    rd_en <= 1'b1;
    repeat (6) @(posedge clk);
    rd_en <= 1'b0;
    #1 `CHK(read_data_bus, 36'h100000000 + 36'(d - 1))
    $display("fill test done, depth %0d", d);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK({full_flag, almost_full_flag, empty_flag, almost_empty_flag}, 4'h3)
    `CHK(read_data_bus, 36'h000000000)
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      width_sel <= 3'(k);
      clr;
      push(36'hFFFFFFFFF, 1);
      pop(36'hFFFFFFFFF, (36'h1 << wbits[k]) - 36'h1, 1);
    end
    $display("width test done");
    fill(DEPTH_1, 128);
    fill(DEPTH_2, 256);
    push(36'h0000000AA, 70);
    idle(15);
    clr;
    `CHK({full_flag, almost_full_flag, empty_flag, almost_empty_flag}, 4'h3)
    push(36'h000000055, 1);
    pop(36'h000000055, 36'hFFFFFFFFF, 1);
    $display("clear test done");
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** include/efc_pkg.sv ***
// package: constants and decode functions for the embedded fifo controller
package efc_pkg;
  localparam int DATA_W = 36;
  localparam int CNT_W = 17;
  localparam int ADDR_W = 16;
  localparam int THR_W = 8;
  localparam int MEM_WORDS = 65536;
  localparam int BASE_BITS = 13;
  localparam int THR_SHIFT = 8;
  // width codes
  localparam logic [2:0] WIDTH_1 = 3'h0;
  localparam logic [2:0] WIDTH_2 = 3'h1;
  localparam logic [2:0] WIDTH_4 = 3'h2;
  localparam logic [2:0] WIDTH_9 = 3'h3;
  localparam logic [2:0] WIDTH_18 = 3'h4;
  localparam logic [2:0] WIDTH_36 = 3'h5;
  // depth selection codes, one bit per cascade size above a single block (DEPTH_1 is zero)
  localparam logic [3:0] DEPTH_1 = 4'h0;
  localparam logic [3:0] DEPTH_2 = 4'h1;
  localparam logic [3:0] DEPTH_4 = 4'h2;
  localparam logic [3:0] DEPTH_8 = 4'h4;
  localparam logic [3:0] DEPTH_16 = 4'h8;
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 17'h00000;
  localparam logic EMPTY_RST = 1'b1;
  localparam logic FULL_RST = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

  // lowest active counter bit for a width code
  function automatic logic [2:0] efc_width_lsb(input logic [2:0] code);
    unique case (code)
      WIDTH_1: return 3'h0;
      WIDTH_2: return 3'h1;
      WIDTH_4: return 3'h2;
      WIDTH_9: return 3'h3;
      WIDTH_18: return 3'h4;
      WIDTH_36: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  // log2 of cascaded blocks
  function automatic logic [2:0] efc_casc(input logic [3:0] sel);
    unique case (sel)
      DEPTH_2: return 3'h1;
      DEPTH_4: return 3'h2;
      DEPTH_8: return 3'h3;
      DEPTH_16: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // mask of active counter bits plus the extra msb
  function automatic logic [CNT_W-1:0] efc_cnt_mask(input logic [2:0] lsb, input logic [2:0] casc);
    logic [4:0] bits;
    logic [CNT_W-1:0] one_hot;
    bits = 5'(BASE_BITS) - 5'(lsb) + 5'(casc);
    one_hot = CNT_RST + (17'h1 << bits);
    return one_hot - 17'h1;
  endfunction

  // data bits used by a width code
  function automatic logic [DATA_W-1:0] efc_data_mask(input logic [2:0] code);
    unique case (code)
      WIDTH_2: return 36'h000000003;
      WIDTH_4: return 36'h00000000F;
      WIDTH_9: return 36'h0000001FF;
      WIDTH_18: return 36'h00003FFFF;
      WIDTH_36: return 36'hFFFFFFFFF;
      default: return 36'h000000001;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] efc_bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] efc_gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = g;
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// *** verilog/efc_almost_cmp.sv ***
// almost-full / almost-empty threshold compare
`timescale 1ns/10ps
`default_nettype none
module efc_almost_cmp #(
  parameter bit FULL_SIDE = 1'b1
) (
  input wire logic [efc_pkg::CNT_W-1:0] gap_cnt,
  input wire logic [2:0] lsb,
  input wire logic [2:0] casc,
  input wire logic [efc_pkg::THR_W-1:0] threshold,
  output logic flag
);
  import efc_pkg::*;
  logic [CNT_W-1:0] occupancy_gap;
  logic [CNT_W-1:0] thr_full;
  logic [THR_W-1:0] thr_mask;

  always_comb begin
    occupancy_gap = gap_cnt << lsb;
    thr_mask = 8'(8'hF0 >> (3'h4 - casc)) | 8'h0F;
    thr_mask = thr_mask & 8'(9'h1FF >> (3'h4 - casc) >> 1) | 8'h0F;
    thr_full = CNT_RST | ({9'h000, threshold & thr_mask} << THR_SHIFT);
    if (FULL_SIDE) begin
      flag = occupancy_gap >= thr_full;
    end else begin
      flag = thr_full >= occupancy_gap;
    end
  end
endmodule
`default_nettype wire

// *** verilog/efc_fifo.sv ***
// embedded fifo controller top: write port, read port, flags, storage
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - each block owns separate write and read ports
// - write and read sides run independently
// - store write data when write enable high
// - read enable and not empty presents next word
// - full flag in write domain blocks writes
// - empty flag in read domain blocks reads
// - address counters count in binary, gray copies cross domains
// - depth follows width and cascade count
// - counter bits 11..5 always active
// - cascade adds upper block-select counter bits
// - inactive counter bits held at zero
// - 8-bit thresholds, only active bits compared
// - comparison widens one bit per cascade doubling
// - almost flags compare gap with threshold shifted
// - threshold width from 4 to 8 bits
// - clear empties fifo and resets all flags
// - extra counter msb separates full from empty
// - empty when read equals synchronised write pointer
// - write pointer double-sampled on read side
// - read pointer double-sampled on write side
// - one 3-bit width code, 11x reserved
// - writes while full leave everything unchanged
// - four-bit depth selection picks cascade size
module efc_fifo (
  input wire logic clk,
  input wire logic srst,
  input wire logic fifo_clear,
  input wire logic [2:0] width_sel,
  input wire logic [3:0] depth_sel,
  input wire logic wr_tick,
  input wire logic wr_en,
  input wire logic [efc_pkg::DATA_W-1:0] write_data_bus,
  input wire logic [efc_pkg::THR_W-1:0] almost_full_threshold,
  output logic full_flag,
  output logic almost_full_flag,
  input wire logic rd_tick,
  input wire logic rd_en,
  input wire logic [efc_pkg::THR_W-1:0] almost_empty_threshold,
  output logic [efc_pkg::DATA_W-1:0] read_data_bus,
  output logic empty_flag,
  output logic almost_empty_flag
);
  import efc_pkg::*;

  logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
  logic [2:0] lsb;
  logic [2:0] casc;
  logic [CNT_W-1:0] mask;
  logic [CNT_W-1:0] depth;
  logic [DATA_W-1:0] dmask;

  // write-side state
  logic [CNT_W-1:0] wcnt;
  logic [CNT_W-1:0] wgray;
  logic [CNT_W-1:0] next_wcnt;
  logic [CNT_W-1:0] next_wgray;
  logic next_full;
  logic next_almost_full_flag;
  logic wr_accept;
  logic [ADDR_W-1:0] write_pointer;
  logic [CNT_W-1:0] rsync_bin;
  logic [CNT_W-1:0] wgap;
  logic af_raw;

  // read-side state
  logic [CNT_W-1:0] rcnt;
  logic [CNT_W-1:0] rgray;
  logic [CNT_W-1:0] next_rcnt;
  logic [CNT_W-1:0] next_rgray;
  logic next_empty;
  logic next_almost_empty_flag;
  logic [DATA_W-1:0] next_rdata;
  logic rd_accept;
  logic [ADDR_W-1:0] read_pointer;
  logic [CNT_W-1:0] wsync_bin;
  logic [CNT_W-1:0] rgap;
  logic ae_raw;
  logic [DATA_W-1:0] rd_word;

  // configuration decode
  always_comb begin
    lsb = efc_width_lsb(width_sel);
    casc = efc_casc(depth_sel);
    mask = efc_cnt_mask(lsb, casc);
    depth = (mask >> 1) + 17'h1;
    dmask = efc_data_mask(width_sel);
  end

  // pointer crossings
  efc_gray_sync u_rd_to_wr (
    .clk(clk),
    .srst(srst),
    .clear(fifo_clear),
    .tick(wr_tick),
    .gray_in(rgray),
    .bin_out(rsync_bin)
  );

  efc_gray_sync u_wr_to_rd (
    .clk(clk),
    .srst(srst),
    .clear(fifo_clear),
    .tick(rd_tick),
    .gray_in(wgray),
    .bin_out(wsync_bin)
  );

  // write side next values
  always_comb begin
    wr_accept = wr_tick && wr_en && !full_flag && !fifo_clear;
    next_wcnt = wcnt;
    if (fifo_clear) begin
      next_wcnt = CNT_RST;
    end else if (wr_accept) begin
      next_wcnt = (wcnt + 17'h1) & mask;
    end
    next_wgray = efc_bin2gray(next_wcnt);
    wgap = (next_wcnt - rsync_bin) & mask;
    next_full = full_flag;
    next_almost_full_flag = almost_full_flag;
    if (fifo_clear) begin
      next_full = FULL_RST;
      next_almost_full_flag = FULL_RST;
    end else if (wr_tick) begin
      next_full = (wgap == depth);
      next_almost_full_flag = af_raw;
    end
    write_pointer = ADDR_W'((wcnt & (mask >> 1)) << lsb);
  end

  efc_almost_cmp #(
    .FULL_SIDE(1'b1)
  ) u_af_cmp (
    .gap_cnt(wgap),
    .lsb(lsb),
    .casc(casc),
    .threshold(almost_full_threshold),
    .flag(af_raw)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      wcnt <= CNT_RST;
      wgray <= CNT_RST;
      full_flag <= FULL_RST;
      almost_full_flag <= FULL_RST;
    end else begin
      wcnt <= next_wcnt;
      wgray <= next_wgray;
      full_flag <= next_full;
      almost_full_flag <= next_almost_full_flag;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (wr_accept) begin
      mem[write_pointer] <= write_data_bus & dmask;
    end
  end

  // read side next values
  always_comb begin
    rd_accept = rd_tick && rd_en && !empty_flag && !fifo_clear;
    read_pointer = ADDR_W'((rcnt & (mask >> 1)) << lsb);
    rd_word = mem[read_pointer];
    next_rcnt = rcnt;
    next_rdata = read_data_bus;
    if (fifo_clear) begin
      next_rcnt = CNT_RST;
    end else if (rd_accept) begin
      next_rcnt = (rcnt + 17'h1) & mask;
      next_rdata = rd_word & dmask;
    end
    next_rgray = efc_bin2gray(next_rcnt);
    rgap = (wsync_bin - next_rcnt) & mask;
    next_empty = empty_flag;
    next_almost_empty_flag = almost_empty_flag;
    if (fifo_clear) begin
      next_empty = EMPTY_RST;
      next_almost_empty_flag = EMPTY_RST;
    end else if (rd_tick) begin
      next_empty = (next_rcnt == wsync_bin);
      next_almost_empty_flag = ae_raw;
    end
  end

  efc_almost_cmp #(
    .FULL_SIDE(1'b0)
  ) u_ae_cmp (
    .gap_cnt(rgap),
    .lsb(lsb),
    .casc(casc),
    .threshold(almost_empty_threshold),
    .flag(ae_raw)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      rcnt <= CNT_RST;
      rgray <= CNT_RST;
      empty_flag <= EMPTY_RST;
      almost_empty_flag <= EMPTY_RST;
      read_data_bus <= DATA_RST;
    end else begin
      rcnt <= next_rcnt;
      rgray <= next_rgray;
      empty_flag <= next_empty;
      almost_empty_flag <= next_almost_empty_flag;
      read_data_bus <= next_rdata;
    end
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_full_blocks_write: assert property (
    full_flag && wr_tick && wr_en && !fifo_clear |=> wcnt == $past(wcnt))
    else $error("write taken while full");

  a_empty_blocks_read: assert property (
    empty_flag && rd_tick && rd_en && !fifo_clear |=> rcnt == $past(rcnt) && read_data_bus == $past(read_data_bus))
    else $error("read taken while empty");

  a_clear_flags: assert property (
    fifo_clear |=> empty_flag && almost_empty_flag && !full_flag && !almost_full_flag && wcnt == 17'h0)
    else $error("clear did not empty fifo");

  a_write_advance: assert property (
    wr_tick && wr_en && !full_flag && !fifo_clear |=> wcnt == (($past(wcnt) + 17'h1) & $past(mask)))
    else $error("write pointer did not advance");

  a_gray_step: assert property (
    !$past(fifo_clear) |-> $countones(wgray ^ $past(wgray)) <= 1)
    else $error("gray pointer changed more than one bit");

  a_read_data: assert property (
    rd_tick && rd_en && !empty_flag && !fifo_clear |=> read_data_bus == ($past(rd_word) & $past(dmask)))
    else $error("read data not presented");

  a_inactive_zero: assert property (
    (wcnt & ~mask) == 17'h0 && (rcnt & ~mask) == 17'h0)
    else $error("inactive counter bit set");

  a_empty_compare: assert property (
    rd_tick && !fifo_clear |=> empty_flag == (rcnt == $past(wsync_bin)))
    else $error("empty flag mismatch");

  a_full_compare: assert property (
    wr_tick && !fifo_clear |=> full_flag == (((wcnt - $past(rsync_bin)) & mask) == depth))
    else $error("full flag mismatch");
endmodule
`default_nettype wire

// *** verilog/efc_gray_sync.sv ***
// two-stage pointer synchroniser, stepping on the receiving side's clock enable
`timescale 1ns/10ps
`default_nettype none
module efc_gray_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [efc_pkg::CNT_W-1:0] gray_in,
  output logic [efc_pkg::CNT_W-1:0] bin_out
);
  import efc_pkg::*;
  logic [CNT_W-1:0] stage1;
  logic [CNT_W-1:0] stage2;
  logic [CNT_W-1:0] next_stage1;
  logic [CNT_W-1:0] next_stage2;

  always_comb begin
    next_stage1 = stage1;
    next_stage2 = stage2;
    if (clear) begin
      next_stage1 = CNT_RST;
      next_stage2 = CNT_RST;
    end else if (tick) begin
      next_stage1 = gray_in;
      next_stage2 = stage1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= CNT_RST;
      stage2 <= CNT_RST;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign bin_out = efc_gray2bin(stage2);
endmodule
`default_nettype wire
